/* logic/acsr_top.sv */
// Purpose: control, status and sequencing of an eight-channel converter
// Assumes: rst is power-on reset; standby clears like it except the read path and pin edge detector
// Notes: reads answer two cycles after the request
`timescale 1ns/1ps
`include "acsr_params.svh"
module acsr_top #(
   parameter int CHANNELS = 8,
   parameter int RES_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic standby,
   input wire logic manual_reset,
   input wire logic [7:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_word,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   output logic bus_rvalid,
   input wire logic timer_trigger,
   input wire logic external_start_pin,
   input wire logic transfer_ack,
   output logic conversion_end_irq,
   output logic core_sample,
   output logic [2:0] core_channel,
   output logic core_clk_div4,
   output logic core_fast_start,
   output logic core_dual_sample,
   input wire logic [9:0] core_result,
   output logic busy
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic end_flag_q;
   logic clear_armed_q;
   logic end_irq_enable_q;
   logic start_q;
   logic conv_clock_select_q;
   logic group_select_q;
   logic [2:0] channel_field_q;
   logic start_speed_select_q;
   logic [1:0] trigger_source_q;
   logic scan_q;
   logic dual_sample_enable_q;
   logic [1:0] buffer_cfg_q;

   logic [7:0] status_rd;
   logic [7:0] mode_rd;
   logic wipe;

   // power-on reset and standby both wipe; manual reset does not
   assign wipe = rst || standby;

   // ----------------------------------------------------------------
   // bus write decode
   // ----------------------------------------------------------------
   logic status_wr;
   logic mode_wr;
   logic [7:0] status_wbyte;
   logic [7:0] mode_wbyte;

   // a word at the status offset carries both bytes, status high
   assign status_wr = bus_wr && (bus_addr == `ACSR_OFF_STATUS);
   assign mode_wr = bus_wr && ((bus_addr == `ACSR_OFF_MODE && !bus_word) ||
                               (bus_addr == `ACSR_OFF_STATUS && bus_word));
   assign status_wbyte = bus_word ? bus_wdata[15:8] : bus_wdata[7:0];
   assign mode_wbyte = bus_wdata[7:0];

   // ----------------------------------------------------------------
   // sequencer signals
   // ----------------------------------------------------------------
   acsr_pkg::acsr_state_e state_q;
   logic [6:0] cnt_q;
   logic [2:0] ch_q;
   logic [2:0] rounds_q;
   logic [2:0] first_ch;
   logic [2:0] stages;
   logic conv_end;
   logic round_end;
   logic flag_set;
   logic auto_stop;
   logic [6:0] conv_load;

   // conversion length in cycles, minus one for a down counter
   assign conv_load = conv_clock_select_q ?
                      7'(`ACSR_CONV_CYC_SLOW - 1) :
                      7'(`ACSR_CONV_CYC_FAST - 1);

   // select mode starts at channel n, group mode at channel 0
   assign first_ch = group_select_q ? 3'h0 : channel_field_q;

   // rounds needed before the flag when buffering in single mode
   always_comb begin
      case (buffer_cfg_q)
         `ACSR_BUF_NONE: stages = 3'h1;
         `ACSR_BUF_ABCD: stages = `ACSR_BUF_STAGES_FOUR;
         default: stages = `ACSR_BUF_STAGES_TWO;
      endcase
   end

   assign conv_end = (state_q == acsr_pkg::ACSR_CONV) && (cnt_q == '0) &&
                     start_q;
   // the last designated channel is always channel n
   assign round_end = conv_end && (ch_q == channel_field_q);

   // flag each scan round; in single mode wait for buffer stages
   assign flag_set = round_end &&
                     (scan_q || (rounds_q + 3'h1 >= stages));
   assign auto_stop = flag_set && !scan_q;

   // ----------------------------------------------------------------
   // trigger detection
   // ----------------------------------------------------------------
   logic pin_q;
   logic pin_fall;
   logic hw_start;

   // external pin starts on a falling edge
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= external_start_pin;
      end
   end
   assign pin_fall = pin_q && !external_start_pin;

   // code 10 is reserved and starts nothing
   assign hw_start =
      ((trigger_source_q == `ACSR_TRIG_TIMER) && timer_trigger) ||
      ((trigger_source_q == `ACSR_TRIG_PIN) && pin_fall);

   // ----------------------------------------------------------------
   // start bit
   // ----------------------------------------------------------------
   // hardware set beats a same-cycle software write; auto clear beats a same-cycle trigger
   always_ff @(posedge clk) begin
      if (wipe) begin
         start_q <= 1'(`ACSR_STATUS_RST >> `ACSR_START_BIT);
      end else if (hw_start && !start_q) begin
         start_q <= 1'b1;
      end else if (status_wr) begin
         start_q <= status_wbyte[`ACSR_START_BIT];
      end else if (auto_stop) begin
         start_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // end flag
   // ----------------------------------------------------------------
   // reading the status byte with the flag at one arms the clear
   always_ff @(posedge clk) begin
      if (wipe) begin
         clear_armed_q <= 1'b0;
      end else if (bus_rd && bus_addr == `ACSR_OFF_STATUS && end_flag_q) begin
         clear_armed_q <= 1'b1;
      end else if (status_wr || !end_flag_q) begin
         clear_armed_q <= 1'b0;
      end
   end

   // a set in the clearing cycle wins so no end event is lost
   always_ff @(posedge clk) begin
      if (wipe) begin
         end_flag_q <= 1'b0;
      end else if (flag_set) begin
         end_flag_q <= 1'b1;
      end else if (transfer_ack && end_flag_q) begin
         end_flag_q <= 1'b0;
      end else if (status_wr && clear_armed_q &&
                   !status_wbyte[`ACSR_END_FLAG_BIT]) begin
         end_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   // settings are taken whenever written; software keeps them still
   // while a conversion runs, so no lockout is built here
   always_ff @(posedge clk) begin
      if (wipe) begin
         end_irq_enable_q <= 1'b0;
         conv_clock_select_q <= 1'b0;
         group_select_q <= 1'b0;
         channel_field_q <= 3'h0;
      end else if (status_wr) begin
         end_irq_enable_q <= status_wbyte[`ACSR_IRQ_EN_BIT];
         conv_clock_select_q <= status_wbyte[`ACSR_CLK_SEL_BIT];
         group_select_q <= status_wbyte[`ACSR_GROUP_BIT];
         channel_field_q <=
            status_wbyte[`ACSR_CHAN_HI:`ACSR_CHAN_LO];
      end
   end

   // mode register; the reserved bit is not stored
   always_ff @(posedge clk) begin
      if (wipe) begin
         start_speed_select_q <= 1'b0;
         trigger_source_q <= `ACSR_TRIG_SW;
         scan_q <= 1'b0;
         dual_sample_enable_q <= 1'b0;
         buffer_cfg_q <= `ACSR_BUF_NONE;
      end else if (mode_wr) begin
         start_speed_select_q <= mode_wbyte[`ACSR_SPEED_BIT];
         trigger_source_q <=
            mode_wbyte[`ACSR_TRIG_HI:`ACSR_TRIG_LO];
         scan_q <= mode_wbyte[`ACSR_SCAN_BIT];
         dual_sample_enable_q <= mode_wbyte[`ACSR_DUAL_BIT];
         buffer_cfg_q <= mode_wbyte[`ACSR_BUF_HI:`ACSR_BUF_LO];
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   // manual reset is ignored here on purpose: registers survive it
   always_ff @(posedge clk) begin
      if (wipe) begin
         state_q <= acsr_pkg::ACSR_IDLE;
         cnt_q <= '0;
         ch_q <= 3'h0;
         rounds_q <= 3'h0;
      end else begin
         case (state_q)
            acsr_pkg::ACSR_IDLE: begin
               if (start_q) begin
                  state_q <= acsr_pkg::ACSR_CONV;
                  cnt_q <= conv_load;
                  ch_q <= first_ch;
                  rounds_q <= 3'h0;
               end
            end
            acsr_pkg::ACSR_CONV: begin
               if (!start_q) begin
                  state_q <= acsr_pkg::ACSR_IDLE;
               end else if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 7'h01;
               end else if (!round_end) begin
                  ch_q <= ch_q + 3'h1;
                  cnt_q <= conv_load;
               end else if (auto_stop) begin
                  state_q <= acsr_pkg::ACSR_IDLE;
               end else if (flag_set && end_irq_enable_q) begin
                  state_q <= acsr_pkg::ACSR_HALT;
                  ch_q <= first_ch;
               end else begin
                  // next round: scan repeat or further buffer stage
                  rounds_q <= rounds_q + 3'h1;
                  ch_q <= first_ch;
                  cnt_q <= conv_load;
               end
            end
            acsr_pkg::ACSR_HALT: begin
               if (!start_q) begin
                  state_q <= acsr_pkg::ACSR_IDLE;
               end else if (!end_flag_q) begin
                  state_q <= acsr_pkg::ACSR_CONV;
                  cnt_q <= conv_load;
               end
            end
            default: begin
               state_q <= acsr_pkg::ACSR_IDLE;
            end
         endcase
      end
   end

   // sample pulse marks the first cycle of each channel conversion
   always_ff @(posedge clk) begin
      if (wipe) begin
         core_sample <= 1'b0;
         core_channel <= 3'h0;
      end else begin
         core_sample <= start_q && (cnt_q == '0 || !busy) &&
                        !(auto_stop || (flag_set && end_irq_enable_q)) &&
                        (state_q != acsr_pkg::ACSR_HALT || !end_flag_q);
         core_channel <= (!busy || round_end) ? first_ch :
                         (cnt_q != '0) ? ch_q : ch_q + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // result storage
   // ----------------------------------------------------------------
   logic [RES_W-1:0] mem_rd_data;
   logic is_result;

   assign is_result = (bus_addr[7:4] == 4'(`ACSR_OFF_RESULT >> 4));

   // conversion result goes to the register of its channel, except a buffer target
   acsr_result_mem #(
      .DEPTH(CHANNELS),
      .WIDTH(RES_W),
      .IW(3)
   ) u_mem (
      .clk(clk),
      .rst(rst),
      .clear(standby),
      .wr_en(conv_end),
      .wr_idx(ch_q),
      .wr_data(core_result),
      .buf_mode(buffer_cfg_q),
      .rd_idx(bus_addr[3:1]),
      .rd_data(mem_rd_data)
   );

   // ----------------------------------------------------------------
   // bus read path
   // ----------------------------------------------------------------
   acsr_pkg::acsr_rsel_e rsel_q;
   logic rword_q;
   logic rpend_q;

   assign status_rd = {end_flag_q, end_irq_enable_q, start_q,
                       conv_clock_select_q, group_select_q,
                       channel_field_q};
   // reserved top bit of the mode register always reads zero
   assign mode_rd = {1'b0, start_speed_select_q, trigger_source_q,
                     scan_q, dual_sample_enable_q, buffer_cfg_q};

   // first read stage: decode and let the memory fetch
   always_ff @(posedge clk) begin
      if (rst) begin
         rsel_q <= acsr_pkg::ACSR_RSEL_NONE;
         rword_q <= 1'b0;
         rpend_q <= 1'b0;
      end else begin
         rpend_q <= bus_rd;
         rword_q <= bus_word;
         if (!bus_rd) begin
            rsel_q <= acsr_pkg::ACSR_RSEL_NONE;
         end else if (is_result) begin
            rsel_q <= acsr_pkg::ACSR_RSEL_RESULT;
         end else if (bus_addr == `ACSR_OFF_STATUS) begin
            rsel_q <= bus_word ? acsr_pkg::ACSR_RSEL_BOTH :
                      acsr_pkg::ACSR_RSEL_STATUS;
         end else if (bus_addr == `ACSR_OFF_MODE) begin
            rsel_q <= acsr_pkg::ACSR_RSEL_MODE;
         end else begin
            rsel_q <= acsr_pkg::ACSR_RSEL_NONE; // unmapped reads zero
         end
      end
   end

   // second read stage: format the answer
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_rdata <= 16'h0000;
         bus_rvalid <= 1'b0;
      end else begin
         bus_rvalid <= rpend_q;
         case (rsel_q)
            acsr_pkg::ACSR_RSEL_STATUS: bus_rdata <= {8'h00, status_rd};
            acsr_pkg::ACSR_RSEL_MODE: bus_rdata <= {8'h00, mode_rd};
            acsr_pkg::ACSR_RSEL_BOTH: bus_rdata <= {status_rd, mode_rd};
            acsr_pkg::ACSR_RSEL_RESULT: begin
               if (rword_q) begin
                  bus_rdata <= {6'h00, mem_rd_data};
               end else begin
                  bus_rdata <= {8'h00, mem_rd_data[9:2]};
               end
            end
            default: bus_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs to the interrupt controller and analog core
   // ----------------------------------------------------------------
   assign conversion_end_irq = end_flag_q && end_irq_enable_q;
   assign core_clk_div4 = conv_clock_select_q;
   assign core_fast_start = start_speed_select_q;
   assign core_dual_sample = dual_sample_enable_q;
   assign busy = (state_q == acsr_pkg::ACSR_CONV);
endmodule

/* pkg/acsr_params.svh */
// Purpose: constants of the converter control and status block
// Assumes: 8-bit registers on a 16-bit processor bus, low address byte
// Notes: offsets are the low byte of the printed register addresses
//
// Summary of operation
// - status register clears on reset and standby
// - mode register clears on reset and standby
// - end flag cleared by read-one then write-zero
// - transfer controller service clears the end flag
// - single mode flags after channels and buffering
// - scan mode flags after each full round
// - interrupt request is flag and enable
// - start bit set by software, timer, pin
// - single mode auto-clears start bit at end
// - scan mode runs until start bit cleared
// - clock select chooses 40 or 80 states
// - group bit picks select or group mode
// - channel field picks channel n or 0..n
// - mode register bit 7 reads zero
// - speed bit picks fast start or low power
// - trigger field picks software, timer or pin
// - scan bit picks single or scan mode
// - dual bit enables two-channel simultaneous sampling
// - buffer field picks result shift arrangement
// - results hold 10 bits, upper bits zero
// - byte read returns top eight result bits
// - scan with interrupt halts until flag cleared
// - clearing start bit stops running conversion
`ifndef ACSR_PARAMS_SVH
`define ACSR_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (low byte of the bus address)
// ----------------------------------------------------------------
`define ACSR_OFF_STATUS 8'he0
`define ACSR_OFF_MODE 8'he1
`define ACSR_OFF_RESULT 8'hf0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACSR_STATUS_RST 8'h00
`define ACSR_MODE_RST 8'h00
`define ACSR_RESULT_RST 10'h000

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ACSR_END_FLAG_BIT 7
`define ACSR_IRQ_EN_BIT 6
`define ACSR_START_BIT 5
`define ACSR_CLK_SEL_BIT 4
`define ACSR_GROUP_BIT 3
`define ACSR_CHAN_HI 2
`define ACSR_CHAN_LO 0

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define ACSR_RSVD_BIT 7
`define ACSR_SPEED_BIT 6
`define ACSR_TRIG_HI 5
`define ACSR_TRIG_LO 4
`define ACSR_SCAN_BIT 3
`define ACSR_DUAL_BIT 2
`define ACSR_BUF_HI 1
`define ACSR_BUF_LO 0

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define ACSR_TRIG_SW 2'h0
`define ACSR_TRIG_TIMER 2'h1
`define ACSR_TRIG_PIN 2'h3
`define ACSR_BUF_NONE 2'h0
`define ACSR_BUF_AB 2'h1
`define ACSR_BUF_AC_BD 2'h2
`define ACSR_BUF_ABCD 2'h3
`define ACSR_BUF_STAGES_TWO 3'h2
`define ACSR_BUF_STAGES_FOUR 3'h4

// ----------------------------------------------------------------
// timing: one state is one system clock cycle
// ----------------------------------------------------------------
`define ACSR_CONV_STATES_FAST 40
`define ACSR_CONV_STATES_SLOW 80
`define ACSR_CYC_PER_STATE 1
`define ACSR_CONV_CYC_FAST (`ACSR_CONV_STATES_FAST * `ACSR_CYC_PER_STATE)
`define ACSR_CONV_CYC_SLOW (`ACSR_CONV_STATES_SLOW * `ACSR_CYC_PER_STATE)

`endif

/* pkg/acsr_pkg.sv */
// Purpose: shared types of the converter control and status block
// Assumes: constants live in acsr_params.svh
// Notes: types only
package acsr_pkg;
   // conversion sequencer states
   typedef enum logic [1:0] {
      ACSR_IDLE,
      ACSR_CONV,
      ACSR_HALT
   } acsr_state_e;

   // which register a pending read returns
   typedef enum logic [2:0] {
      ACSR_RSEL_NONE,
      ACSR_RSEL_STATUS,
      ACSR_RSEL_MODE,
      ACSR_RSEL_BOTH,
      ACSR_RSEL_RESULT
   } acsr_rsel_e;

   typedef logic [9:0] acsr_result_t;
endpackage

/* logic/acsr_result_mem.sv */
// Purpose: eight result registers with buffer shifting
// Assumes: one write per cycle, registered read port
// Notes: buffer targets are never written directly in buffer modes
`timescale 1ns/1ps
`include "acsr_params.svh"
module acsr_result_mem #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 10,
   parameter int IW = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [IW-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [1:0] buf_mode,
   input wire logic [IW-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // ----------------------------------------------------------------
   // per-entry write and shift
   // ----------------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      logic hit;
      logic shift;
      logic [IW-1:0] src;

      // decide whether this entry takes new data or its predecessor
      always_comb begin
         hit = (wr_idx == IW'(i));
         shift = 1'b0;
         src = IW'(i);
         case (buf_mode)
            `ACSR_BUF_AB: begin
               hit = (wr_idx == IW'(i)) && (i != 1);
               shift = (i == 1) && (wr_idx == '0);
               src = '0;
            end
            `ACSR_BUF_AC_BD: begin
               hit = (wr_idx == IW'(i)) && (i != 2) && (i != 3);
               shift = ((i == 2) && (wr_idx == IW'(0))) ||
                       ((i == 3) && (wr_idx == IW'(1)));
               src = IW'(i + DEPTH - 2);
            end
            `ACSR_BUF_ABCD: begin
               hit = (wr_idx == IW'(i)) && ((i == 0) || (i > 3));
               shift = (i >= 1) && (i <= 3) && (wr_idx == '0);
               src = IW'(i + DEPTH - 1);
            end
            default: begin
               hit = (wr_idx == IW'(i));
            end
         endcase
      end

      // storage; cleared by reset and standby only
      always_ff @(posedge clk) begin
         if (rst || clear) begin
            mem_q[i] <= `ACSR_RESULT_RST;
         end else if (wr_en && hit) begin
            mem_q[i] <= wr_data;
         end else if (wr_en && shift) begin
            mem_q[i] <= mem_q[src];
         end
      end
   end

   // registered read port
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_q[rd_idx];
      end
   end
endmodule

/* tb/acsr_core_model.sv */
// Purpose: stand-in for the analog converter core
// Assumes: the channel is steady while core_sample is high
// Notes: result encodes the channel so every store can be traced
`timescale 1ns/1ps
module acsr_core_model (
   input wire logic clk,
   input wire logic core_sample,
   input wire logic [2:0] core_channel,
   output logic [9:0] core_result
);
   // latch at each channel start; unknown until then, so stray stores show
   always_ff @(posedge clk) begin
      if (core_sample) begin
         core_result <= {core_channel, 7'h2a};
      end
   end
endmodule

/* tb/acsr_props.sv */
// Purpose: port-level checks of the converter control block
// Assumes: reads answer two cycles after the request
// Notes: bound to acsr_top, sees its ports only
`timescale 1ns/1ps
module acsr_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic standby,
   input wire logic [7:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_word,
   input wire logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic bus_rvalid,
   input wire logic conversion_end_irq,
   input wire logic core_sample,
   input wire logic core_clk_div4,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] gap_q;
   logic run_q;
   // cycles since the last channel start; the first start has no gap
   always_ff @(posedge clk) begin
      run_q <= !rst && busy && (run_q || core_sample);
      gap_q <= (rst || !busy || core_sample) ? 8'h01 : gap_q + 8'h01;
   end
   sequence start_wr;
      bus_wr && !bus_word && bus_addr == 8'he0 && bus_wdata[5] && !busy;
   endsequence
   sequence answer;
      ##2 bus_rvalid;
   endsequence
   start_run_a: assert property (start_wr |-> ##[1:2] busy
      ##[0:2] core_sample) else $error("start write began no conversion");
   reset_quiet_a: assert property ($fell(rst) |-> !busy && !bus_rvalid
      && !conversion_end_irq && bus_rdata == 16'h0000)
      else $error("outputs not cleared by reset");
   standby_quiet_a: assert property (standby |=> !busy
      && !conversion_end_irq) else $error("standby left the block running");
   conv_spacing_a: assert property (core_sample && run_q
      |-> gap_q == (core_clk_div4 ? 8'h50 : 8'h28))
      else $error("channel conversion length wrong");
   mode_rsvd_a: assert property (bus_rd && !bus_word && bus_addr == 8'he1
      |-> answer ##0 !bus_rdata[7]) else $error("reserved mode bit read one");
   word_rsvd_a: assert property (bus_rd && bus_word && bus_addr == 8'he0
      |-> answer ##0 !bus_rdata[7]) else $error("reserved bit in word read");
   result_upper_a: assert property (bus_rd && bus_word && &bus_addr[7:4]
      |-> answer ##0 bus_rdata[15:10] == 6'h00) else $error("result top bits");
   byte_result_a: assert property (bus_rd && !bus_word && &bus_addr[7:4]
      |-> answer ##0 bus_rdata[15:8] == 8'h00) else $error("result byte read");
endmodule
bind acsr_top acsr_props u_props (.clk(clk), .rst(rst), .standby(standby),
   .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .busy(busy),
   .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .bus_rvalid(bus_rvalid), .conversion_end_irq(conversion_end_irq),
   .core_sample(core_sample), .core_clk_div4(core_clk_div4));

/* tb/testbench.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: byte accesses unless a read asks for a word
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst = 1'b1, standby = 1'b0, manual_reset = 1'b0;
   logic bus_rd = 1'b0, bus_wr = 1'b0, bus_word = 1'b0;
   logic timer_trigger = 1'b0, external_start_pin = 1'b1;
   logic transfer_ack = 1'b0, bus_rvalid, conversion_end_irq, busy;
   logic core_sample, core_clk_div4, core_fast_start, core_dual_sample;
   logic [7:0] bus_addr = 8'h00;
   logic [15:0] bus_wdata = 16'h0000, bus_rdata;
   logic [2:0] core_channel;
   logic [9:0] core_result;
   int err_total = 0, checks_done = 0;
   // address, byte written, byte read back
   logic [23:0] rows [6] = '{24'he1ff7f, 24'he15e5e, 24'he10000,
      24'he01f1f, 24'he08000, 24'he85a00};
   always #4 clk = ~clk;
   acsr_top dut (.clk(clk), .rst(rst), .standby(standby),
      .manual_reset(manual_reset), .bus_addr(bus_addr), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_word(bus_word), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .busy(busy),
      .timer_trigger(timer_trigger), .transfer_ack(transfer_ack),
      .external_start_pin(external_start_pin), .core_result(core_result),
      .conversion_end_irq(conversion_end_irq), .core_sample(core_sample),
      .core_channel(core_channel), .core_clk_div4(core_clk_div4),
      .core_fast_start(core_fast_start), .core_dual_sample(core_dual_sample));
   acsr_core_model core (.clk(clk), .core_sample(core_sample),
      .core_channel(core_channel), .core_result(core_result));
   task automatic complete_run(input bit hung);
      if (hung) err_total++;
      if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [9:0] res(input logic [2:0] n);
      return {n, 7'h2a};
   endfunction
   // one-cycle strobe on any input
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      bus_addr = a;
      bus_wdata = {8'h00, d};
      bus_word = 1'b0;
      pulse(bus_wr);
   endtask
   // read is taken at one edge, the answer waited for under a bound
   task automatic rc(input logic [7:0] a, input logic w, input logic [15:0] e);
      bus_addr = a;
      bus_word = w;
      pulse(bus_rd);
      for (int i = 0; i < 4 && bus_rvalid !== 1'b1; i++) @(negedge clk);
      if (bus_rvalid !== 1'b1) complete_run(1'b1);
      chk(bus_rdata, e);
   endtask
   // conversion must have started, then finish within the bound
   task automatic idle();
      repeat (3) @(negedge clk);
      chk(16'(busy), 16'h0001);
      for (int i = 0; i < 600 && busy !== 1'b0; i++) @(negedge clk);
      if (busy !== 1'b0) complete_run(1'b1);
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      rc(8'he0, 1'b1, 16'h0000);
      // settings are only written while idle
      foreach (rows[r]) begin
         wr(rows[r][23:16], rows[r][15:8]);
         rc(rows[r][23:16], 1'b0, {8'h00, rows[r][7:0]});
      end
      wr(8'he0, 8'h1f);
      wr(8'he1, 8'h5e);
      chk(16'({core_fast_start, core_dual_sample}), 16'h0003);
      pulse(manual_reset);
      rc(8'he0, 1'b1, 16'h1f5e);
      pulse(standby);
      rc(8'he0, 1'b1, 16'h0000);
      wr(8'he0, 8'h73);
      idle();
      chk(16'(conversion_end_irq), 16'h0001);
      wr(8'he0, 8'hd3);
      wr(8'he0, 8'h53);
      rc(8'he0, 1'b0, 16'h00d3);
      wr(8'he0, 8'h53);
      rc(8'he0, 1'b0, 16'h0053);
      chk(16'(conversion_end_irq), 16'h0000);
      rc(8'hf6, 1'b1, {6'h00, res(3'h3)});
      rc(8'hf6, 1'b0, 16'h006a);
      wr(8'he1, 8'h10);
      wr(8'he0, 8'h0a);
      pulse(timer_trigger);
      idle();
      chk(16'(conversion_end_irq), 16'h0000);
      rc(8'he0, 1'b0, 16'h008a);
      for (int n = 0; n < 3; n++) begin
         rc(8'hf0 + 8'(2 * n), 1'b1, {6'h00, res(n[2:0])});
      end
      pulse(transfer_ack);
      rc(8'he0, 1'b0, 16'h000a);
      wr(8'he1, 8'h20);
      pulse(external_start_pin);
      pulse(timer_trigger);
      repeat (3) @(negedge clk);
      chk(16'(busy), 16'h0000);
      wr(8'he1, 8'h30);
      pulse(external_start_pin);
      idle();
      rc(8'he0, 1'b0, 16'h008a);
      wr(8'he1, 8'h08);
      wr(8'he0, 8'h20);
      repeat (100) @(negedge clk);
      chk(16'(busy), 16'h0001);
      wr(8'he0, 8'h00);
      repeat (3) @(negedge clk);
      chk(16'(busy), 16'h0000);
      rc(8'he0, 1'b0, 16'h0080);
      wr(8'he0, 8'h60);
      repeat (60) @(negedge clk);
      chk(16'(busy), 16'h0000);
      rc(8'he0, 1'b0, 16'h00e0);
      wr(8'he0, 8'h60);
      repeat (3) @(negedge clk);
      chk(16'(busy), 16'h0001);
      wr(8'he0, 8'h00);
      complete_run(1'b0);
   end
endmodule
